// *** rtl/pe_ctrl_pkg.sv ***
// package of constants shared by the dual processing element control block
// Overview of operation
// - bit twenty-one of the operating control word enables the secondary element
// - enable low: computations run only in the primary element
// - enable high: both elements run computations
// - enable change takes effect one cycle after the write
// - shift-by-immediate uses the immediate as second operand in both elements
// - in dual mode each compute instruction goes to both elements together
// - in dual mode each transfer loads two data sets and stores both results
// - both elements are identical: ALU, multiplier result pair, shifter, sticky status
// - interrupt entry can mask selected arithmetic mode bits automatically
// - shifter raises no arithmetic exceptions; only ALU and multiplier do
// - sticky status registers update one cycle after the exception
// - arithmetic interrupt processing begins two cycles after the exception
// - enabled exception in either element raises interrupt, not naming the element
// - return from interrupt keeps sticky flags; software must clear them
// - ALU exceptions use priorities 33 to 36 and the four vectors
// - multiplier exceptions share priorities 33 to 36 and the same vectors
package pe_ctrl_pkg;
   localparam int WORD_W = 32;
   localparam int MODE_W = 32;
   localparam int SEC_EN_BIT = 21;
   localparam int SHORT_SIGN_BIT = 0;
   localparam int ROUND_TOWARD_ZERO_SELECT_SEL_BIT = 1;
   localparam int ALU_SAT_BIT = 2;
   localparam int RND_SINGLE_BIT = 3;
   localparam int MUL_SWAP_BIT = 4;
   localparam logic [MODE_W-1:0] MODE_RESET = 32'h0000_0000;
   // only the five arithmetic mode bits may be masked on isr entry
   localparam logic [MODE_W-1:0] ARITH_MODE_MASK = 32'h0000_001F;
   // exception kinds: index into the four sticky bits of each unit
   localparam int EXC_N = 4;
   localparam int EXC_FIX_OVF = 0;
   localparam int EXC_FLT_OVF = 1;
   localparam int EXC_FLT_UNF = 2;
   localparam int EXC_FLT_INV = 3;
   // sticky layout: alu kinds in [3:0], multiplier kinds in [7:4]
   localparam int STICKY_W = 8;
   localparam int ALU_STICKY_LSB = 0;
   localparam int MUL_STICKY_LSB = 4;
   localparam logic [STICKY_W-1:0] STICKY_RESET = 8'h00;
   localparam logic [5:0] PRIO_FIX_OVF = 6'h21;
   localparam logic [5:0] PRIO_FLT_OVF = 6'h22;
   localparam logic [5:0] PRIO_FLT_UNF = 6'h23;
   localparam logic [5:0] PRIO_FLT_INV = 6'h24;
   // vector identifiers are a local encoding of the four entries
   localparam logic [1:0] fixed_overflow_vector = 2'h0;
   localparam logic [1:0] float_overflow_vector = 2'h1;
   localparam logic [1:0] float_underflow_vector = 2'h2;
   localparam logic [1:0] float_invalid_vector = 2'h3;
   localparam int EXEC_LAT = 1;
   localparam int IRQ_LAT = 2;
   typedef enum logic [1:0] {OP_ADD, OP_MUL, OP_SHIFT_IMM, OP_NONE} op_e;
endpackage : pe_ctrl_pkg

// *** rtl/processing_element.sv ***
// one processing element: alu, multiplier result pair, shifter, sticky status
`timescale 1ns/1ps
module processing_element
   import pe_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic active,
   input wire logic [1:0] op,
   input wire logic [WORD_W-1:0] opnd_a,
   input wire logic [WORD_W-1:0] opnd_b,
   input wire logic [7:0] shift_imm,
   input wire logic alu_sat,
   input wire logic mul_swap,
   input wire logic [EXC_N-1:0] alu_exc,
   input wire logic [EXC_N-1:0] mul_exc,
   input wire logic [STICKY_W-1:0] sticky_clr,
   output logic [WORD_W-1:0] result,
   output logic [WORD_W-1:0] mul_fg,
   output logic [WORD_W-1:0] mul_bg,
   output logic [STICKY_W-1:0] sticky
);
   logic [WORD_W:0] sum;
   logic [WORD_W-1:0] alu_val;
   logic [WORD_W-1:0] prod;
   logic go;

   assign go = active & clk_en;
   assign sum = {1'b0, opnd_a} + {1'b0, opnd_b};
   // saturation clips unsigned carry out rather than wrapping
   assign alu_val = (alu_sat && sum[WORD_W]) ? {WORD_W{1'b1}} : sum[WORD_W-1:0];
   assign prod = WORD_W'(opnd_a * opnd_b);

   // result register; shifter second operand is the immediate field
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result <= '0;
      end else if (go) begin
         case (op_e'(op))
            OP_ADD: result <= alu_val;
            OP_SHIFT_IMM: result <= opnd_a << shift_imm;
            default: result <= result;
         endcase
      end
   end

   // multiplier result pair; swap bit picks which one receives the product
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mul_fg <= '0;
         mul_bg <= '0;
      end else if (go && op_e'(op) == OP_MUL) begin
         if (mul_swap) begin
            mul_bg <= prod;
         end else begin
            mul_fg <= prod;
         end
      end
   end

   // sticky status: new exceptions win over a clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sticky <= STICKY_RESET;
      end else if (clk_en) begin
         sticky <= (sticky & ~sticky_clr) | (go ? {mul_exc, alu_exc} : STICKY_RESET);
      end
   end
endmodule : processing_element

// *** rtl/dual_pe_ctrl.sv ***
// dual processing element control: mode word, dual dispatch, arithmetic interrupts
`timescale 1ns/1ps
module dual_pe_ctrl
   import pe_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic mode_wr,
   input wire logic [MODE_W-1:0] mode_wdata,
   input wire logic [MODE_W-1:0] isr_mode_mask,
   input wire logic isr_enter,
   input wire logic isr_return,
   input wire logic instr_valid,
   input wire logic [1:0] instr_op,
   input wire logic [7:0] instr_shift_imm,
   input wire logic [WORD_W-1:0] load_a_primary,
   input wire logic [WORD_W-1:0] load_b_primary,
   input wire logic [WORD_W-1:0] load_a_secondary,
   input wire logic [WORD_W-1:0] load_b_secondary,
   input wire logic [EXC_N-1:0] alu_exc_primary,
   input wire logic [EXC_N-1:0] mul_exc_primary,
   input wire logic [EXC_N-1:0] alu_exc_secondary,
   input wire logic [EXC_N-1:0] mul_exc_secondary,
   input wire logic [STICKY_W-1:0] sticky_clr_primary,
   input wire logic [STICKY_W-1:0] sticky_clr_secondary,
   input wire logic [EXC_N-1:0] exc_irq_enable,
   output logic [MODE_W-1:0] operating_control_word,
   output logic secondary_element_enable,
   output logic [WORD_W-1:0] store_primary,
   output logic [WORD_W-1:0] store_secondary,
   output logic store_valid,
   output logic store_dual,
   output logic [WORD_W-1:0] mul_fg_primary,
   output logic [WORD_W-1:0] mul_bg_primary,
   output logic [WORD_W-1:0] mul_fg_secondary,
   output logic [WORD_W-1:0] mul_bg_secondary,
   output logic [STICKY_W-1:0] sticky_status_primary,
   output logic [STICKY_W-1:0] sticky_status_secondary,
   output logic [EXC_N-1:0] exc_irq,
   output logic exc_irq_valid,
   output logic [5:0] exc_irq_priority,
   output logic [1:0] exc_irq_vector
);
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] saved_mode_q;
   logic sec_en_q;
   logic in_isr_q;
   logic issue_q;
   logic issue_dual_q;
   logic [WORD_W-1:0] res_p;
   logic [WORD_W-1:0] res_s;
   logic [STICKY_W-1:0] stk_p;
   logic [STICKY_W-1:0] stk_s;
   logic [EXC_N-1:0] pend_q;
   logic [EXC_N-1:0] pending;
   logic alu_sat;
   logic mul_swap;

   // operating control word; isr entry masks selected arithmetic bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RESET;
         saved_mode_q <= MODE_RESET;
         in_isr_q <= 1'b0;
      end else if (clk_en) begin
         if (mode_wr) begin
            mode_q <= mode_wdata;
         end else if (isr_enter && !in_isr_q) begin
            saved_mode_q <= mode_q;
            mode_q <= mode_q & ~(isr_mode_mask & ARITH_MODE_MASK);
            in_isr_q <= 1'b1;
         end else if (isr_return && in_isr_q) begin
            // restore only the masked arithmetic bits; the sticky flags are untouched
            mode_q <= (mode_q & ~(isr_mode_mask & ARITH_MODE_MASK)) |
               (saved_mode_q & isr_mode_mask & ARITH_MODE_MASK);
            in_isr_q <= 1'b0;
         end
      end
   end

   // effective enable trails the word by one cycle so the next instruction keeps the old mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sec_en_q <= 1'b0;
      end else if (clk_en) begin
         sec_en_q <= mode_q[SEC_EN_BIT];
      end
   end

   assign alu_sat = mode_q[ALU_SAT_BIT];
   assign mul_swap = mode_q[MUL_SWAP_BIT];

   // two identical elements fed the same instruction and immediate
   processing_element u_primary (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .active(instr_valid),
      .op(instr_op),
      .opnd_a(load_a_primary),
      .opnd_b(load_b_primary),
      .shift_imm(instr_shift_imm),
      .alu_sat(alu_sat),
      .mul_swap(mul_swap),
      .alu_exc(alu_exc_primary),
      .mul_exc(mul_exc_primary),
      .sticky_clr(sticky_clr_primary),
      .result(res_p),
      .mul_fg(mul_fg_primary),
      .mul_bg(mul_bg_primary),
      .sticky(stk_p)
   );

   processing_element u_secondary (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .active(instr_valid & sec_en_q),
      .op(instr_op),
      .opnd_a(load_a_secondary),
      .opnd_b(load_b_secondary),
      .shift_imm(instr_shift_imm),
      .alu_sat(alu_sat),
      .mul_swap(mul_swap),
      .alu_exc(alu_exc_secondary),
      .mul_exc(mul_exc_secondary),
      .sticky_clr(sticky_clr_secondary),
      .result(res_s),
      .mul_fg(mul_fg_secondary),
      .mul_bg(mul_bg_secondary),
      .sticky(stk_s)
   );

   assign sticky_status_primary = stk_p;
   assign sticky_status_secondary = stk_s;

   // issue tracking: a store carries one word per active element
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         issue_q <= 1'b0;
         issue_dual_q <= 1'b0;
      end else if (clk_en) begin
         issue_q <= instr_valid;
         issue_dual_q <= instr_valid & sec_en_q;
      end
   end

   // store outputs registered once more so they come from flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         store_primary <= '0;
         store_secondary <= '0;
         store_valid <= 1'b0;
         store_dual <= 1'b0;
      end else if (clk_en) begin
         store_primary <= res_p;
         store_secondary <= res_s;
         store_valid <= issue_q;
         store_dual <= issue_dual_q;
      end
   end

   // shifter has no exception input, so only alu and multiplier kinds reach here
   generate
      for (genvar k = 0; k < EXC_N; k++) begin : g_kind
         assign pending[k] = exc_irq_enable[k] &
            (stk_p[ALU_STICKY_LSB+k] | stk_p[MUL_STICKY_LSB+k] |
             stk_s[ALU_STICKY_LSB+k] | stk_s[MUL_STICKY_LSB+k]);
      end
   endgenerate

   // interrupt request one cycle after sticky, two after the exception
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= '0;
      end else if (clk_en) begin
         pend_q <= pending;
      end
   end

   // priority pick: lowest number wins, shared by alu and multiplier sources
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         exc_irq_valid <= 1'b0;
         exc_irq_priority <= '0;
         exc_irq_vector <= fixed_overflow_vector;
      end else if (clk_en) begin
         exc_irq_valid <= |pend_q;
         if (pend_q[EXC_FIX_OVF]) begin
            exc_irq_priority <= PRIO_FIX_OVF;
            exc_irq_vector <= fixed_overflow_vector;
         end else if (pend_q[EXC_FLT_OVF]) begin
            exc_irq_priority <= PRIO_FLT_OVF;
            exc_irq_vector <= float_overflow_vector;
         end else if (pend_q[EXC_FLT_UNF]) begin
            exc_irq_priority <= PRIO_FLT_UNF;
            exc_irq_vector <= float_underflow_vector;
         end else begin
            exc_irq_priority <= PRIO_FLT_INV;
            exc_irq_vector <= float_invalid_vector;
         end
      end
   end

   assign exc_irq = pend_q;
   assign operating_control_word = mode_q;
   assign secondary_element_enable = sec_en_q;

   // disabled secondary keeps its sticky bits apart from software clears
   property p_sec_frozen;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && !sec_en_q && sticky_clr_secondary == '0) |=> $stable(stk_s);
   endproperty
   a_sec_frozen: assert property (p_sec_frozen) else $error("secondary sticky changed while off");

   property p_mode_lat;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && mode_wr) |=> clk_en |=> (sec_en_q == $past(mode_wdata[SEC_EN_BIT], 2));
   endproperty
   a_mode_lat: assert property (p_mode_lat) else $error("enable latency wrong");

   sequence s_exc;
      clk_en && exc_irq_enable[EXC_FIX_OVF] && alu_exc_primary[EXC_FIX_OVF] && instr_valid;
   endsequence
   property p_irq_two;
      @(posedge clock) disable iff (!rst_n)
      s_exc ##1 (clk_en && $stable(exc_irq_enable)) |=> exc_irq[EXC_FIX_OVF];
   endproperty
   a_irq_two: assert property (p_irq_two) else $error("irq not two cycles after exception");

   property p_sticky_one;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && instr_valid && mul_exc_primary[EXC_FLT_INV]) |=> stk_p[MUL_STICKY_LSB+EXC_FLT_INV];
   endproperty
   a_sticky_one: assert property (p_sticky_one) else $error("sticky not set next cycle");

   property p_rti_keeps;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && isr_return && sticky_clr_primary == '0 && stk_p[EXC_FIX_OVF]) |=> stk_p[EXC_FIX_OVF];
   endproperty
   a_rti_keeps: assert property (p_rti_keeps) else $error("return cleared sticky");

   property p_isr_mask;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && isr_enter && !in_isr_q && !mode_wr && isr_mode_mask[ALU_SAT_BIT])
         |=> !mode_q[ALU_SAT_BIT];
   endproperty
   a_isr_mask: assert property (p_isr_mask) else $error("mode bit not masked");

   property p_either_pe;
      @(posedge clock) disable iff (!rst_n)
      (exc_irq_enable[EXC_FLT_OVF] && (stk_s[EXC_FLT_OVF] || stk_p[MUL_STICKY_LSB+EXC_FLT_OVF]) && clk_en)
         |=> exc_irq[EXC_FLT_OVF] || !clk_en;
   endproperty
   a_either_pe: assert property (p_either_pe) else $error("element exception lost");

   property p_prio;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && pend_q[EXC_FIX_OVF]) |=> (exc_irq_priority == PRIO_FIX_OVF);
   endproperty
   a_prio: assert property (p_prio) else $error("wrong priority");

   property p_dual_store;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && instr_valid && !sec_en_q) ##1 clk_en |=> !store_dual;
   endproperty
   a_dual_store: assert property (p_dual_store) else $error("dual store in single mode");
endmodule : dual_pe_ctrl

// *** testbench/dual_pe_simd_and_arith_exceptions_bench.sv ***
// self-checking bench for the dual processing element control block
`timescale 1ns/1ps
module dual_pe_simd_and_arith_exceptions_bench;
   import pe_ctrl_pkg::*;
   typedef struct packed {logic [WORD_W-1:0] p; logic [WORD_W-1:0] s; logic dual; logic pair;} store_note_s;
   typedef struct packed {logic [EXC_N-1:0] irq; logic [5:0] prio; logic [1:0] vec;} irq_note_s;
   logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, mode_wr = 1'b0, isr_enter = 1'b0, isr_return = 1'b0;
   logic instr_valid = 1'b0, store_valid, store_dual, exc_irq_valid, secondary_element_enable, irq_prev = 1'b0;
   logic [1:0] instr_op = 2'h3, exc_irq_vector;
   logic [7:0] instr_shift_imm = 8'h00;
   logic [MODE_W-1:0] mode_wdata = '0, isr_mode_mask = '0, operating_control_word;
   logic [WORD_W-1:0] la_p = '0, lb_p = '0, la_s = '0, lb_s = '0, store_primary, store_secondary;
   logic [WORD_W-1:0] mfp, mbp, mfs, mbs;
   logic [EXC_N-1:0] ae_p = '0, me_p = '0, ae_s = '0, me_s = '0, exc_irq_enable = 4'hF, exc_irq;
   logic [STICKY_W-1:0] clr_p = '0, clr_s = '0, sticky_status_primary, sticky_status_secondary;
   logic [5:0] exc_irq_priority;
   logic [31:0] seed = 32'h4D024A63;
   store_note_s store_q[$];
   irq_note_s irq_q[$];
   int mismatches = 0, samples_checked = 0;

   dual_pe_ctrl DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .isr_mode_mask(isr_mode_mask), .isr_enter(isr_enter), .isr_return(isr_return), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_shift_imm(instr_shift_imm), .load_a_primary(la_p), .load_b_primary(lb_p),
      .load_a_secondary(la_s), .load_b_secondary(lb_s), .alu_exc_primary(ae_p), .mul_exc_primary(me_p),
      .alu_exc_secondary(ae_s), .mul_exc_secondary(me_s), .sticky_clr_primary(clr_p),
      .sticky_clr_secondary(clr_s), .exc_irq_enable(exc_irq_enable), .operating_control_word(operating_control_word),
      .secondary_element_enable(secondary_element_enable), .store_primary(store_primary),
      .store_secondary(store_secondary), .store_valid(store_valid), .store_dual(store_dual), .mul_fg_primary(mfp),
      .mul_bg_primary(mbp), .mul_fg_secondary(mfs), .mul_bg_secondary(mbs),
      .sticky_status_primary(sticky_status_primary), .sticky_status_secondary(sticky_status_secondary),
      .exc_irq(exc_irq), .exc_irq_valid(exc_irq_valid), .exc_irq_priority(exc_irq_priority),
      .exc_irq_vector(exc_irq_vector));

   // 250 MHz core clock
   initial begin
      forever #2 clock = ~clock;
   end

   function automatic logic [31:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : next_rand

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // inputs change 1 ns after the rising edge, clear of the sampling point
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   task automatic write_mode(input logic [MODE_W-1:0] w);
      mode_wr = 1'b1;
      mode_wdata = w;
      tick();
      mode_wr = 1'b0;
   endtask : write_mode

   // one compute instruction; the expected store is noted for the watcher
   task automatic issue(input logic [1:0] op, input logic [31:0] a, b, c, d, input logic dual);
      instr_valid = 1'b1;
      instr_op = op;
      instr_shift_imm = 8'(next_rand() & 32'h1F);
      la_p = a;
      lb_p = b;
      la_s = c;
      lb_s = d;
      store_q.push_back({a + b, c + d, dual, op == OP_SHIFT_IMM});
      tick();
      instr_valid = 1'b0;
   endtask : issue

   // raise one exception kind in one unit of one element, then service and clear it
   task automatic raise(input int k, unit, elem, input logic [EXC_N-1:0] en, input logic act, dual);
      logic [EXC_N-1:0] v;
      logic [STICKY_W-1:0] sb;
      logic want;
      int n;
      v = 4'h1 << k;
      sb = act ? 8'h01 << (unit * 4 + k) : 8'h00;
      want = act && en[k];
      exc_irq_enable = en;
      {ae_p, me_p, ae_s, me_s} = {v, v, v, v} & (16'hF000 >> (4 * (elem * 2 + unit)));
      if (want) irq_q.push_back({v, 6'h21 + 6'(k), 2'(k)});
      issue(OP_ADD, 32'h0, 32'h0, 32'h0, 32'h0, dual);
      {ae_p, me_p, ae_s, me_s} = '0;
      check(elem ? sticky_status_secondary : sticky_status_primary, sb, "sticky set");
      n = 0;
      while (want && exc_irq_valid !== 1'b1 && n < 10) begin
         tick();
         n++;
      end
      if (want) check(n, 2, "irq latency");
      repeat (3) tick();
      check(exc_irq_valid, want, "irq raised");
      isr_enter = 1'b1;
      tick();
      isr_enter = 1'b0;
      isr_return = 1'b1;
      tick();
      isr_return = 1'b0;
      check(elem ? sticky_status_secondary : sticky_status_primary, sb, "sticky after return");
      clr_p = 8'hFF;
      clr_s = 8'hFF;
      tick();
      clr_p = 8'h00;
      clr_s = 8'h00;
      repeat (4) tick();
      check({exc_irq_valid, exc_irq}, 5'h00, "irq cleared");
   endtask : raise

   // watcher: compares each add result against the oldest note, shift results against each other
   always @(posedge clock) begin
      store_note_s sn;
      irq_note_s in;
      irq_prev <= exc_irq_valid;
      if (store_valid === 1'b1) begin
         if (store_q.size() == 0) check(1'b1, 1'b0, "unexpected store");
         else begin
            sn = store_q.pop_front();
            check(store_dual, sn.dual, "store dual");
            if (sn.pair) check(store_secondary, store_primary, "same immediate");
            else check(store_primary, sn.p, "primary result");
            if (sn.dual && !sn.pair) check(store_secondary, sn.s, "secondary result");
         end
      end
      if (exc_irq_valid === 1'b1 && irq_prev !== 1'b1) begin
         if (irq_q.size() == 0) check(1'b1, 1'b0, "unexpected irq");
         else begin
            in = irq_q.pop_front();
            check({exc_irq, exc_irq_priority, exc_irq_vector}, in, "irq kind");
         end
      end
   end

   // watchdog sized well above the sequence length
   initial begin
      #40000;
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      logic [31:0] a, b, m;
      repeat (8) @(posedge clock);
      #1;
      rst_n = 1'b1;
      check({operating_control_word, secondary_element_enable, exc_irq_valid}, 34'h0, "reset state");
      a = next_rand() & 32'h3FFF_FFFF;
      b = next_rand() & 32'h3FFF_FFFF;
      issue(OP_ADD, a, b, b, b, 1'b0);
      write_mode(32'h0020_0000);
      check(operating_control_word[SEC_EN_BIT], 1'b1, "word bit");
      issue(OP_ADD, b, a, a, a, 1'b0);
      check(secondary_element_enable, 1'b1, "enable effective");
      issue(OP_ADD, a, a, b, b, 1'b1);
      issue(OP_SHIFT_IMM, a, b, a, b, 1'b1);
      $display("test mode switch done");
      for (int k = 0; k < EXC_N; k++) begin
         for (int u = 0; u < 2; u++) begin
            raise(k, u, (k + u) % 2, 4'hF, 1'b1, 1'b1);
         end
      end
      raise(2, 0, 0, 4'hB, 1'b1, 1'b1);
      $display("test simd exceptions done");
      write_mode(32'h0000_0000);
      tick();
      raise(1, 1, 1, 4'hF, 1'b0, 1'b0);
      issue(OP_ADD, a, b, 32'h5, 32'h7, 1'b0);
      $display("test single mode done");
      write_mode(32'h0020_001F);
      for (int i = 0; i < 3; i++) begin
         m = next_rand() & 32'h1F;
         isr_mode_mask = m;
         isr_enter = 1'b1;
         tick();
         isr_mode_mask = 32'h1F;
         tick();
         check(operating_control_word, 32'h0020_001F & ~m, "isr mask");
         tick();
         isr_enter = 1'b0;
         isr_return = 1'b1;
         tick();
         isr_return = 1'b0;
         tick();
         check(operating_control_word, 32'h0020_001F, "isr restore");
      end
      $display("test isr mask done");
      // clock enable low: a mode write must not land
      clk_en = 1'b0;
      write_mode(32'h0000_0000);
      tick();
      check(operating_control_word, 32'h0020_001F, "frozen word");
      check(secondary_element_enable, 1'b1, "frozen enable");
      clk_en = 1'b1;
      tick();
      $display("test clock enable done");
      repeat (4) tick();
      check(store_q.size() + irq_q.size(), 0, "notes drained");
      report_and_stop();
   end
endmodule : dual_pe_simd_and_arith_exceptions_bench
